// [shared/ccp_params.svh]
// constants of the codec control port: offsets, fields, defaults, counts
// assumes inclusion by bare name from package and design files
`ifndef CCP_PARAMS_SVH
`define CCP_PARAMS_SVH

// register map
`define CCP_NREG          11
`define CCP_ADDR_W        5
`define CCP_REG_RESET     5'h09
`define CCP_REG_POWER     5'h0a
`define CCP_TIMING_RESET_BIT_BIT      0
`define CCP_DAC_ON_BIT    0
`define CCP_ADC_ON_BIT    1
// defaults, index 0ah down to 00h
`define CCP_REG_DEFAULTS  {8'h3f, 8'h01, 8'h15, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h08}

// serial frame layout
`define CCP_FRAME_BITS    5'h10
`define CCP_FRAME_OVER    5'h11
`define CCP_I2C_FIXED     5'h04

// frame-clock period figures and the tick counts derived from them
`define CCP_ADC_INIT_FS   522
`define CCP_ADC_INIT_CNT  10'(`CCP_ADC_INIT_FS + 1)
`define CCP_PDN_ZF_FS     10
`define CCP_PDN_ZF_CNT    4'(`CCP_PDN_ZF_FS + 1)
`define CCP_RST_DLY_FS    4
`define CCP_RST_DLY_CNT   3'(`CCP_RST_DLY_FS + 1)
`define CCP_REL_FS        6
`define CCP_REL_CNT       3'(`CCP_REL_FS + 1)

`endif

// [shared/ccp_pkg.sv]
// types of the codec control port
// assumes ccp_params.svh on the include path
`include "ccp_params.svh"

package ccp_pkg;

    // synchronised pin group
    typedef struct packed {
        logic pdn_n;
        logic fclk;
        logic sclk;
        logic sdi;
        logic sel_n;
        logic i2c_mode;
        logic chip_addr_pin1;
        logic chip_addr_pin0;
    } ccp_pins_t;

    typedef logic [`CCP_NREG-1:0][7:0] ccp_regs_t;

    typedef enum logic [1:0] {
        CCP_I2C_IDLE = 2'b00,
        CCP_I2C_RECV = 2'b01,
        CCP_I2C_ACK  = 2'b10
    } ccp_i2c_t;

    typedef struct packed {
        ccp_pins_t s1;
        ccp_pins_t s2;
    } ccp_sync_t;

    typedef struct packed {
        ccp_pins_t pins_q;
        ccp_regs_t regs;
        logic [15:0] sh3;
        logic [4:0]  cnt3;
        ccp_i2c_t    i2c;
        logic [3:0]  ibit;
        logic [7:0]  ibyte;
        logic [1:0]  inum;
        logic [4:0]  iptr;
        logic        sda_oe;
        logic [9:0]  adc_cnt;
        logic [3:0]  zf_hold;
        logic [2:0]  rst_cnt;
        logic [2:0]  rel_cnt;
        logic        zf1;
        logic        zf2;
        logic        sdo;
        logic        adc_run;
        logic        dac_run;
        logic        filt_rst;
        logic        tim_rst;
        logic        wr_pulse;
    } ccp_state_t;

endpackage : ccp_pkg

// [hdl/ccp_sync.sv]
// two-stage synchroniser for the control and frame pins
// assumes pins are asynchronous to mclk_i
`timescale 1ns/1ps

module ccp_sync
    import ccp_pkg::*;
(
    // clock and reset
    input  logic      mclk_i,
    input  logic      sys_rst_i,
    // pins
    input  ccp_pins_t pins_i,
    output ccp_pins_t pins_o
);

    ccp_sync_t st;
    ccp_sync_t next_st;

    ////////////////////////////////////////////////////////////////////////
    // first stage feeds the second only
    always_comb
    begin
        next_st.s1 = pins_i;
        next_st.s2 = st.s1;
    end

    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign pins_o = st.s2;

endmodule : ccp_sync

// [hdl/ccp_top.sv]
// codec control port with power-down and timing-reset sequencing
// assumes pins asynchronous to mclk_i; adc and zero-detect inputs on mclk_i
`timescale 1ns/1ps
`include "ccp_params.svh"

module ccp_top
    import ccp_pkg::*;
(
    // clock and reset
    input  logic        mclk_i,
    input  logic        sys_rst_i,
    // power and frame pins
    input  logic        power_down_n_i,
    input  logic        frame_clock_i,
    // control port pins
    input  logic        i2c_mode_i,
    input  logic        ctrl_select_n_i,
    input  logic        ctrl_shift_clock_i,
    input  logic        ctrl_serial_in_i,
    output logic        ctrl_serial_out_o,
    output logic        ctrl_serial_oe_o,
    input  logic        chip_addr_pin0_i,
    input  logic        chip_addr_pin1_i,
    // converter side
    input  logic        adc_data_i,
    input  logic [1:0]  zero_detect_i,
    output logic        adc_serial_out_o,
    output logic        zero_flag_one_o,
    output logic        zero_flag_two_o,
    output logic        adc_run_o,
    output logic        dac_run_o,
    output logic        filter_reset_o,
    output logic        timing_reset_o,
    // register contents
    output ccp_regs_t   regs_o,
    output logic        reg_write_o
);

    ccp_state_t st;
    ccp_state_t next_st;
    ccp_pins_t  raw;
    ccp_pins_t  p;

    ////////////////////////////////////////////////////////////////////////
    // pin capture

    assign raw.pdn_n    = power_down_n_i;
    assign raw.fclk     = frame_clock_i;
    assign raw.sclk     = ctrl_shift_clock_i;
    assign raw.sdi      = ctrl_serial_in_i;
    assign raw.sel_n    = ctrl_select_n_i;
    assign raw.i2c_mode = i2c_mode_i;
    assign raw.chip_addr_pin1     = chip_addr_pin1_i;
    assign raw.chip_addr_pin0     = chip_addr_pin0_i;

    ccp_sync u_sync (
        .mclk_i    (mclk_i),
        .sys_rst_i (sys_rst_i),
        .pins_i    (raw),
        .pins_o    (p)
    );

    ////////////////////////////////////////////////////////////////////////
    // edges, seen only on synchronised pins

    logic       fs_tick;
    logic       sclk_rise;
    logic       sclk_fall;
    logic       sel_rise;
    logic       sel_fall;
    logic       i2c_start;
    logic       i2c_stop;
    logic [1:0] cad;

    assign fs_tick   = p.fclk & ~st.pins_q.fclk;
    assign sclk_rise = p.sclk & ~st.pins_q.sclk;
    assign sclk_fall = ~p.sclk & st.pins_q.sclk;
    assign sel_rise  = p.sel_n & ~st.pins_q.sel_n;
    assign sel_fall  = ~p.sel_n & st.pins_q.sel_n;
    assign i2c_start = p.sclk & st.pins_q.sclk & st.pins_q.sdi & ~p.sdi;
    assign i2c_stop  = p.sclk & st.pins_q.sclk & ~st.pins_q.sdi & p.sdi;
    assign cad       = {p.chip_addr_pin1, p.chip_addr_pin0};

    ////////////////////////////////////////////////////////////////////////
    // next state

    logic       wr_en;
    logic [4:0] wr_addr;
    logic [7:0] wr_data;
    logic       timing_reset_bit_bit;
    logic       adc_on;
    logic       dac_on;
    logic       hold_low;
    logic       hold_high;

    always_comb
    begin
        next_st        = st;
        next_st.pins_q = p;
        wr_en          = 1'b0;
        wr_addr        = 5'h00;
        wr_data        = 8'h00;
        timing_reset_bit_bit       = 1'b0;
        adc_on         = 1'b0;
        dac_on         = 1'b0;
        hold_low       = 1'b0;
        hold_high      = 1'b0;

        if (!p.i2c_mode)
        begin
            // 3-wire port
            next_st.i2c    = CCP_I2C_IDLE;
            next_st.sda_oe = 1'b0;
            if (sel_fall)
            begin
                next_st.cnt3 = 5'h00;
            end
            else if (!p.sel_n && sclk_rise)
            begin
                next_st.sh3 = {st.sh3[14:0], p.sdi};
                if (st.cnt3 != `CCP_FRAME_OVER)
                begin
                    next_st.cnt3 = st.cnt3 + 5'h01;
                end
            end
            // short or long frames never commit
            if (sel_rise && st.cnt3 == `CCP_FRAME_BITS)
            begin
                if (st.sh3[15:14] == cad && st.sh3[13])
                begin
                    wr_en   = 1'b1;
                    wr_addr = st.sh3[12:8];
                    wr_data = st.sh3[7:0];
                end
            end
        end
        else
        begin
            // i2c slave, receive only
            if (i2c_start)
            begin
                next_st.i2c    = CCP_I2C_RECV;
                next_st.ibit   = 4'h0;
                next_st.inum   = 2'h0;
                next_st.sda_oe = 1'b0;
            end
            else if (i2c_stop)
            begin
                next_st.i2c    = CCP_I2C_IDLE;
                next_st.sda_oe = 1'b0;
            end
            else
            begin
                unique case (st.i2c)
                    CCP_I2C_IDLE:
                    begin
                        next_st.sda_oe = 1'b0;
                    end
                    CCP_I2C_RECV:
                    begin
                        if (sclk_rise)
                        begin
                            next_st.ibyte = {st.ibyte[6:0], p.sdi};
                            next_st.ibit  = st.ibit + 4'h1;
                        end
                        else if (sclk_fall && st.ibit == 4'h8)
                        begin
                            next_st.i2c    = CCP_I2C_ACK;
                            next_st.sda_oe = 1'b1;
                            unique case (st.inum)
                                2'h0:
                                begin
                                    // read direction or foreign address: stay silent
                                    if (st.ibyte != {`CCP_I2C_FIXED, cad, 1'b0})
                                    begin
                                        next_st.i2c    = CCP_I2C_IDLE;
                                        next_st.sda_oe = 1'b0;
                                    end
                                    next_st.inum = 2'h1;
                                end
                                2'h1:
                                begin
                                    next_st.iptr = st.ibyte[4:0];
                                    next_st.inum = 2'h2;
                                end
                                default:
                                begin
                                    wr_en        = 1'b1;
                                    wr_addr      = st.iptr;
                                    wr_data      = st.ibyte;
                                    next_st.iptr = st.iptr + 5'h01;
                                end
                            endcase
                        end
                    end
                    CCP_I2C_ACK:
                    begin
                        // release after the ninth clock
                        if (sclk_fall)
                        begin
                            next_st.sda_oe = 1'b0;
                            next_st.i2c    = CCP_I2C_RECV;
                            next_st.ibit   = 4'h0;
                        end
                    end
                    default:
                    begin
                        next_st.i2c    = CCP_I2C_IDLE;
                        next_st.sda_oe = 1'b0;
                    end
                endcase
            end
        end

        // register file; writes while powered down are dropped
        next_st.wr_pulse = 1'b0;
        if (wr_en && p.pdn_n && wr_addr < 5'(`CCP_NREG))
        begin
            next_st.regs[wr_addr[3:0]] = wr_data;
            next_st.wr_pulse           = 1'b1;
        end

        // power-down and timing reset sequencing
        if (!p.pdn_n)
        begin
            next_st.regs    = `CCP_REG_DEFAULTS;
            next_st.adc_cnt = `CCP_ADC_INIT_CNT;
            next_st.zf_hold = `CCP_PDN_ZF_CNT;
            next_st.rst_cnt = `CCP_RST_DLY_CNT;
            next_st.rel_cnt = 3'h0;
        end
        else
        begin
            if (fs_tick && st.adc_cnt != 10'h000)
            begin
                next_st.adc_cnt = st.adc_cnt - 10'h001;
            end
            if (fs_tick && st.zf_hold != 4'h0)
            begin
                next_st.zf_hold = st.zf_hold - 4'h1;
            end
            if (!st.regs[`CCP_REG_RESET][`CCP_TIMING_RESET_BIT_BIT])
            begin
                next_st.rel_cnt = `CCP_REL_CNT;
                if (fs_tick && st.rst_cnt != 3'h0)
                begin
                    next_st.rst_cnt = st.rst_cnt - 3'h1;
                end
            end
            else
            begin
                // frame clock must be running again here
                next_st.rst_cnt = `CCP_RST_DLY_CNT;
                if (fs_tick && st.rel_cnt != 3'h0)
                begin
                    next_st.rel_cnt = st.rel_cnt - 3'h1;
                end
            end
        end

        timing_reset_bit_bit = next_st.regs[`CCP_REG_RESET][`CCP_TIMING_RESET_BIT_BIT];
        adc_on   = next_st.regs[`CCP_REG_POWER][`CCP_ADC_ON_BIT];
        dac_on   = next_st.regs[`CCP_REG_POWER][`CCP_DAC_ON_BIT];

        next_st.tim_rst  = p.pdn_n & ~timing_reset_bit_bit & (next_st.rst_cnt == 3'h0);
        next_st.filt_rst = ~p.pdn_n;
        next_st.adc_run  = p.pdn_n & adc_on & ~next_st.tim_rst;
        next_st.dac_run  = p.pdn_n & dac_on & ~next_st.tim_rst;
        next_st.sdo      = p.pdn_n & adc_on & timing_reset_bit_bit
                         & (next_st.adc_cnt == 10'h000) & adc_data_i;

        hold_low  = ~p.pdn_n | (next_st.zf_hold != 4'h0);
        hold_high = ~dac_on | ~timing_reset_bit_bit | (next_st.rel_cnt != 3'h0);
        if (hold_low)
        begin
            next_st.zf1 = 1'b0;
            next_st.zf2 = 1'b0;
        end
        else if (hold_high)
        begin
            next_st.zf1 = 1'b1;
            next_st.zf2 = 1'b1;
        end
        else
        begin
            next_st.zf1 = zero_detect_i[0];
            next_st.zf2 = zero_detect_i[1];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            st         <= '0;
            st.regs    <= `CCP_REG_DEFAULTS;
            st.adc_cnt <= `CCP_ADC_INIT_CNT;
            st.zf_hold <= `CCP_PDN_ZF_CNT;
            st.rst_cnt <= `CCP_RST_DLY_CNT;
        end
        else
        begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs, all from flip-flops except the constant ctrl_serial_out_o

    // open-drain: only ever pulls low
    assign ctrl_serial_out_o = 1'b0;
    assign ctrl_serial_oe_o  = st.sda_oe;
    assign adc_serial_out_o  = st.sdo;
    assign zero_flag_one_o   = st.zf1;
    assign zero_flag_two_o   = st.zf2;
    assign adc_run_o         = st.adc_run;
    assign dac_run_o         = st.dac_run;
    assign filter_reset_o    = st.filt_rst;
    assign timing_reset_o    = st.tim_rst;
    assign regs_o            = st.regs;
    assign reg_write_o       = st.wr_pulse;

endmodule : ccp_top

// [dv/ccp_asserts.sv]
// checker on the codec control port top ports
// assumes 100 MHz mclk_i and an 80 ns frame clock
`timescale 1ns/1ps
`include "ccp_params.svh"

module ccp_asserts
    import ccp_pkg::*;
(
    // clock and reset
    input logic       mclk_i,
    input logic       sys_rst_i,
    // pins
    input logic       power_down_n_i,
    input logic       i2c_mode_i,
    input logic       ctrl_select_n_i,
    input logic [1:0] zero_detect_i,
    // outputs
    input logic       ctrl_serial_oe_o,
    input logic       adc_serial_out_o,
    input logic       zero_flag_one_o,
    input logic       zero_flag_two_o,
    input logic       filter_reset_o,
    input logic       timing_reset_o,
    input ccp_regs_t  regs_o,
    input logic       reg_write_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);

    ////////////////////////////////////////////////////////////////////////////
    property p_defaults;
        $fell(sys_rst_i) |-> regs_o == `CCP_REG_DEFAULTS;
    endproperty
    a_defaults: assert property (p_defaults) else $error("defaults wrong");
    // five cycles cover the two sync stages and the output register
    property p_pdn;
        !power_down_n_i [*5] |-> regs_o == `CCP_REG_DEFAULTS && filter_reset_o && !zero_flag_one_o && !zero_flag_two_o;
    endproperty
    a_pdn: assert property (p_pdn) else $error("power-down state wrong");
    property p_nowr;
        !power_down_n_i [*5] |-> !reg_write_o;
    endproperty
    a_nowr: assert property (p_nowr) else $error("write in power-down");
    property p_adc_off;
        !regs_o[10][1] [*2] |-> !adc_serial_out_o;
    endproperty
    a_adc_off: assert property (p_adc_off) else $error("adc output not low");
    property p_trst_now;
        $fell(regs_o[9][0]) |-> ##[0:2] (zero_flag_one_o && zero_flag_two_o && !adc_serial_out_o);
    endproperty
    a_trst_now: assert property (p_trst_now) else $error("timing reset outputs wrong");
    property p_trst_dly;
        $fell(regs_o[9][0]) |-> ##[28:46] $rose(timing_reset_o);
    endproperty
    a_trst_dly: assert property (p_trst_dly) else $error("internal reset delay wrong");
    property p_trst_rel;
        $rose(regs_o[9][0]) && power_down_n_i && zero_detect_i == 2'b00
            |-> ##1 !timing_reset_o ##43 zero_flag_one_o ##[1:24] !zero_flag_one_o;
    endproperty
    a_trst_rel: assert property (p_trst_rel) else $error("flag release wrong");
    property p_pdn_rel;
        $rose(power_down_n_i) && zero_detect_i == 2'b11 |-> ##76 !zero_flag_one_o ##[1:24] zero_flag_one_o;
    endproperty
    a_pdn_rel: assert property (p_pdn_rel) else $error("flag hold wrong");
    property p_commit;
        $rose(reg_write_o) && !i2c_mode_i |-> ctrl_select_n_i && $past(ctrl_select_n_i, 2);
    endproperty
    a_commit: assert property (p_commit) else $error("commit before select rise");
    property p_oe;
        ctrl_serial_oe_o |-> i2c_mode_i && ctrl_select_n_i;
    endproperty
    a_oe: assert property (p_oe) else $error("drive outside i2c");

    c_ack: cover property ($rose(ctrl_serial_oe_o));
    c_i2c_wr: cover property (reg_write_o && i2c_mode_i);
    c_trst: cover property ($rose(timing_reset_o));
endmodule : ccp_asserts

bind ccp_top ccp_asserts u_chk (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .power_down_n_i(power_down_n_i),
    .i2c_mode_i(i2c_mode_i), .ctrl_select_n_i(ctrl_select_n_i), .zero_detect_i(zero_detect_i),
    .ctrl_serial_oe_o(ctrl_serial_oe_o), .adc_serial_out_o(adc_serial_out_o), .zero_flag_one_o(zero_flag_one_o),
    .zero_flag_two_o(zero_flag_two_o), .filter_reset_o(filter_reset_o), .timing_reset_o(timing_reset_o),
    .regs_o(regs_o), .reg_write_o(reg_write_o));

// [dv/ccp_host.sv]
// host model: 3-wire frames and i2c writes, 80 ns link clock
// assumes tasks are called just after a rising mclk_i edge
`timescale 1ns/1ps

module ccp_host
(
    // clock
    input  logic mclk_i,
    // data wire level
    input  logic sda_i,
    // host drive
    output logic sel_n_o,
    output logic scl_o,
    output logic dat_o
);
    initial
    begin
        sel_n_o = 1'b1; // held high in i2c mode
        scl_o   = 1'b1;
        dat_o   = 1'b1;
    end

    task automatic hp(input int n);
        repeat (n) @(posedge mclk_i);
    endtask : hp

    // data moves only while the clock is low, never beside its edge
    task automatic tick(input logic d);
        scl_o <= 1'b0;
        hp(2);
        dat_o <= d;
        hp(2);
        scl_o <= 1'b1;
        hp(4);
    endtask : tick

    // n below 16 ends the frame early
    task automatic wr3(input logic [15:0] f, input int n);
        sel_n_o <= 1'b0;
        hp(4);
        for (int i = 15; i > 15 - n; i--)
            tick(f[i]);
        hp(4);
        sel_n_o <= 1'b1;
        dat_o   <= ~dat_o;
        hp(8);
    endtask : wr3

    task automatic byte8(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--)
            tick(b[i]);
        tick(1'b1);
        ack = ~sda_i;
    endtask : byte8

    // register byte carries three zero bits on top
    task automatic wri2c(input logic [7:0] a, input logic [4:0] r, input logic [23:0] d, input int nd,
                         output int acks);
        logic ack;
        acks = 0;
        dat_o <= 1'b1;
        hp(4);
        dat_o <= 1'b0;
        hp(4);
        byte8(a, ack);
        if (ack)
        begin
            acks++;
            byte8({3'b000, r}, ack);
            acks += ack;
            for (int i = 0; i < nd; i++)
            begin
                byte8(d[23 - 8 * i -: 8], ack);
                acks += ack;
            end
        end
        scl_o <= 1'b0;
        hp(2);
        dat_o <= 1'b0;
        hp(2);
        scl_o <= 1'b1;
        hp(4);
        dat_o <= 1'b1;
        hp(8);
    endtask : wri2c
endmodule : ccp_host

// [dv/test_codec_control_port_power_reset.sv]
// bench for the codec control port, host model on the pins
// assumes ccp_params.svh on the include path
`timescale 1ns/1ps
`include "ccp_params.svh"

module test_codec_control_port_power_reset
    import ccp_pkg::*;
;
    logic mclk_i = 1'b0, rst = 1'b1, power_down_n = 1'b0, mode = 1'b0, adc = 1'b1, fclk = 1'b0;
    logic [1:0] cad = 2'b10, zd = 2'b11;
    logic sel, scl, dat, oe, so, sdo, zf1, zf2, arun, drun, frst, trst, wr;
    ccp_regs_t regs;
    int miscompares = 0, tests_run = 0, nwr = 0;
    // open drain: device value wins only while it drives
    wire sda = oe ? so : dat;

    always @(posedge mclk_i)
        if (wr === 1'b1)
            nwr <= nwr + 1;

    always #5 mclk_i = ~mclk_i;
    always #40 fclk = ~fclk; // runs free, never stopped

    ccp_top DUT (.mclk_i(mclk_i), .sys_rst_i(rst), .power_down_n_i(power_down_n), .frame_clock_i(fclk), .i2c_mode_i(mode),
        .ctrl_select_n_i(sel), .ctrl_shift_clock_i(scl), .ctrl_serial_in_i(sda), .ctrl_serial_out_o(so),
        .ctrl_serial_oe_o(oe), .chip_addr_pin0_i(cad[0]), .chip_addr_pin1_i(cad[1]), .adc_data_i(adc),
        .zero_detect_i(zd), .adc_serial_out_o(sdo), .zero_flag_one_o(zf1), .zero_flag_two_o(zf2),
        .adc_run_o(arun), .dac_run_o(drun), .filter_reset_o(frst), .timing_reset_o(trst), .regs_o(regs),
        .reg_write_o(wr));
    ccp_host u_host (.mclk_i(mclk_i), .sda_i(sda), .sel_n_o(sel), .scl_o(scl), .dat_o(dat));

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [87:0] seen, input logic [87:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : summarize

    // one frame period is eight mclk cycles
    task automatic fw(input int n);
        repeat (n * 8) @(posedge mclk_i);
    endtask : fw

    task automatic w(input logic [4:0] a, input logic [7:0] d);
        int n;
        u_host.wri2c(8'h24, a, {d, 16'h0000}, 1, n);
        chk("acks", n, 3);
    endtask : w

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_init();
        chk("defaults", regs, `CCP_REG_DEFAULTS);
        chk("flags pd", {zf1, zf2}, 2'b00);
        power_down_n <= 1'b1;
        fw(9);
        chk("flags held", {zf1, zf2}, 2'b00);
        fw(5);
        chk("flags free", {zf1, zf2}, 2'b11);
        fw(506);
        chk("adc init", sdo, 1'b0);
        fw(14);
        chk("adc run", sdo, 1'b1);
        zd <= 2'b00;
    endtask : t_init

    task automatic t_wire3();
        ccp_regs_t e;
        int n0;
        n0 = nwr;
        e = `CCP_REG_DEFAULTS;
        e[2] = 8'ha5;
        u_host.wr3({2'b10, 1'b1, 5'h02, 8'ha5}, 16);
        chk("3w write", regs[2], 8'ha5);
        u_host.wr3({2'b01, 1'b1, 5'h02, 8'h11}, 16);
        u_host.wr3({2'b10, 1'b0, 5'h02, 8'h22}, 16);
        u_host.wr3({2'b10, 1'b1, 5'h02, 8'h33}, 12);
        u_host.wr3({2'b10, 1'b1, 5'h0b, 8'h44}, 16);
        chk("3w refused", regs, e);
        chk("3w writes", nwr - n0, 1);
    endtask : t_wire3

    task automatic t_i2c();
        int n;
        mode <= 1'b1;
        power_down_n <= 1'b0;
        fw(2);
        power_down_n <= 1'b1;
        fw(534);
        u_host.wri2c(8'h24, 5'h1f, 24'h775ac3, 3, n);
        chk("acks wrap", n, 5);
        chk("wrap", regs[1:0], 16'hc35a);
        u_host.wri2c(8'h25, 5'h02, 24'h0, 1, n);
        chk("read nak", n, 0);
        u_host.wri2c(8'h2c, 5'h02, 24'h0, 1, n);
        chk("fixed nak", n, 0);
        u_host.wri2c(8'h22, 5'h02, 24'h0, 1, n);
        chk("pins nak", n, 0);
    endtask : t_i2c

    task automatic t_power();
        w(5'h0a, 8'h3e);
        chk("dac off", {zf1, zf2, drun}, 3'b110);
        w(5'h0a, 8'h3d);
        chk("adc off", {sdo, arun, zf1, zf2}, 4'b0000);
        w(5'h0a, 8'h3f);
        w(5'h09, 8'h00);
        chk("trst now", {zf1, zf2, sdo}, 3'b110);
        fw(6);
        chk("trst in", {trst, regs[1:0]}, 17'h1c35a);
        w(5'h09, 8'h01);
        chk("trst out", {trst, zf1, zf2}, 3'b011);
        fw(6);
        chk("flags fall", {zf1, zf2}, 2'b00);
        power_down_n <= 1'b0;
        fw(1);
        w(5'h02, 8'h99);
        chk("pd regs", regs, `CCP_REG_DEFAULTS);
        chk("pd flags", {frst, zf1, zf2}, 3'b100);
        power_down_n <= 1'b1;
    endtask : t_power

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (10) @(posedge mclk_i);
        rst <= 1'b0;
        repeat (4) @(posedge mclk_i);
        t_init();
        t_wire3();
        t_i2c();
        t_power();
        summarize();
    end

    initial
    begin
        repeat (40000) @(posedge mclk_i);
        miscompares++;
        summarize();
    end
endmodule : test_codec_control_port_power_reset
